// *** mcc_column.sv ***
// Column-time memory interface: status codes, address mux, bus sizing, timing
`timescale 1ns/1ps
`include "mcc_consts.svh"

module mcc_column (
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    RESETN_I,
	input  wire logic                    PSEL_I,
	input  wire logic                    PENABLE_I,
	input  wire logic                    PWRITE_I,
	input  wire logic [11:0]             PADDR_I,
	input  wire logic [31:0]             PWDATA_I,
	output logic      [31:0]             PRDATA_O,
	output logic                         PREADY_O,
	output logic                         PSLVERR_O,
	input  wire logic                    REQ_VALID_I,
	output logic                         REQ_READY_O,
	input  wire mcc_pkg::mcc_req_t       REQ_I,
	output logic                         DONE_O,
	output logic      [63:0]             RDATA_O,
	input  wire mcc_pkg::mcc_sel_t       SEL_I,
	output logic      [5:0]              MEM_STATUS_O,
	output logic      [31:0]             MEM_ADDR_O,
	output logic                         MEM_ROW_O,
	output logic                         MEM_COL_O,
	output logic      [7:0]              MEM_BYTE_EN_O,
	output logic      [63:0]             MEM_DATA_O,
	output logic                         MEM_DATA_OE_N_O,
	input  wire logic [63:0]             MEM_DATA_I,
	output mcc_pkg::mcc_timing_t         TIMING_O
);
	import mcc_pkg::*;

	mcc_state_t  state_r;
	mcc_req_t    req_r;
	mcc_sel_t    sel_r;
	mcc_timing_t tim_r;
	logic [1:0]  ctrl_r;
	logic [3:0]  p_r;
	logic [3:0]  chunk_r;
	logic [3:0]  rem_r;
	logic [2:0]  cnt_r;
	logic [63:0] rdata_r;
	logic [31:0] prdata_r;

	// Column code from the requesting unit; reserved codes cannot be produced
	function automatic logic [5:0] col_code(input mcc_requester_t w, input logic last);
		case (w.unit)
			MCC_SRC_PP:      col_code = {2'b00, w.pp_num, w.kind};
			MCC_SRC_MP_PT:   col_code = {`MCC_ST_MP_PT, w.kind};
			MCC_SRC_MP_IC:   col_code = {`MCC_ST_MP_ICACHE, w.high_pri};
			MCC_SRC_MP_DEA:  col_code = {`MCC_ST_MP_DEA, w.high_pri};
			MCC_SRC_MP_DC:   col_code = {`MCC_ST_MP_DCACHE, w.high_pri};
			MCC_SRC_XPT:     col_code = last ? `MCC_ST_XPT_END : `MCC_ST_XPT_RUN;
			MCC_SRC_FRAME0:  col_code = `MCC_ST_FRAME0;
			MCC_SRC_FRAME1:  col_code = `MCC_ST_FRAME1;
			MCC_SRC_REFRESH: col_code = `MCC_ST_REFRESH;
			MCC_SRC_DRAIN:   col_code = `MCC_ST_DRAIN;
			default:         col_code = `MCC_ST_IDLE_CODE;
		endcase
	endfunction

	// Column address: upper pins carry the logical address shifted by 7 plus the select; select 0 leaves it unshifted
	function automatic logic [31:0] col_addr(input logic [31:0] a, input logic [2:0] s);
		logic [31:0] v;
		v = a << (`MCC_SHIFT_BASE + {3'd0, s});
		v[2:0] = a[2:0];
		col_addr = (s == 3'd0) ? a : v;
	endfunction

	function automatic mcc_timing_t timing_of(input mcc_sel_t s);
		mcc_timing_t t;
		t = '0;
		if (s.cycle_timing_sel[2]) begin
			t.cyc_per_col = (s.cycle_timing_sel[1:0] == 2'd0) ? 2'd1 :
				s.cycle_timing_sel[1:0];
			t.pipelined = (s.cycle_timing_sel[1:0] == 2'd0);
		end else if (s.user_timing_bit) begin
			t.sdram = 1'b1;
			t.burst_two = s.cycle_timing_sel[1];
			t.read_lat = s.cycle_timing_sel[0] ? `MCC_LAT_SDRAM_HI : `MCC_LAT_SDRAM_LO;
			t.cyc_per_col = 2'd1;
		end else begin
			t.sdram = 1'b1;
			t.burst_two = s.cycle_timing_sel[1];
			t.read_lat = `MCC_LAT_SDRAM_USR;
			t.cyc_per_col = 2'd1;
			t.reserved = ~s.cycle_timing_sel[0];
		end
		timing_of = t;
	endfunction

	// Byte k of a doubleword sits on lane k mod w, mirrored to the top lanes in big endian
	function automatic logic [2:0] lane_of(input logic [2:0] k, input logic [3:0] w,
		input logic be);
		logic [2:0] m;
		m = k & (w[2:0] - 3'd1);
		if (w == 4'd8) begin
			m = k;
		end
		lane_of = be ? (3'd7 - m) : m;
	endfunction

	// True when byte k lies in the column starting at offset p that carries n bytes
	function automatic logic in_col(input int k, input logic [3:0] p, input logic [3:0] n);
		in_col = (4'(k) >= p) && (4'(k) < p + n);
	endfunction

	function automatic logic [3:0] width_of(input logic [1:0] bs);
		width_of = 4'd1 << bs;
	endfunction

	// Next column set-up, from the row-time inputs on the first column
	mcc_sel_t    cur_sel;
	mcc_timing_t cur_tim;
	logic [3:0]  width;
	logic [3:0]  nxt_p;
	logic [3:0]  nxt_rem;
	logic [3:0]  grp_room;
	logic [3:0]  nxt_chunk;
	logic        nxt_last;
	logic [7:0]  nxt_en;
	logic [63:0] nxt_data;
	logic [63:0] cap_data;
	logic [2:0]  nxt_cnt;
	logic        be;

	assign be = ctrl_r[`MCC_CTRL_BE_BIT];

	always_comb begin
		cur_sel = (state_r == MCC_ROW) ? SEL_I : sel_r;
		cur_tim = timing_of(cur_sel);
		width = width_of(cur_sel.bus_width_sel);
		nxt_p = (state_r == MCC_ROW) ? {1'b0, req_r.addr[2:0]} : p_r + chunk_r;
		nxt_rem = (state_r == MCC_ROW) ? req_r.nbytes : rem_r - chunk_r;
		grp_room = ((nxt_p | (width - 4'd1)) + 4'd1) - nxt_p;
		nxt_chunk = (nxt_rem < grp_room) ? nxt_rem : grp_room;
		nxt_last = (nxt_rem <= nxt_chunk);
		nxt_en = '0;
		nxt_data = '0;
		for (int k = 0; k < 8; k++) begin
			if (in_col(k, nxt_p, nxt_chunk)) begin
				nxt_en[lane_of(3'(k), width, be)] = 1'b1;
				nxt_data[8 * lane_of(3'(k), width, be) +: 8] = req_r.wdata[8 * k +: 8];
			end
		end
		nxt_cnt = (cur_tim.sdram && !req_r.write) ? cur_tim.read_lat :
			{1'b0, cur_tim.cyc_per_col};
	end

	// Read bytes gathered back from the lanes of the column just ending
	always_comb begin
		cap_data = rdata_r;
		for (int k = 0; k < 8; k++) begin
			if (in_col(k, p_r, chunk_r)) begin
				cap_data[8 * k +: 8] =
					MEM_DATA_I[8 * lane_of(3'(k), width_of(sel_r.bus_width_sel), be) +: 8];
			end
		end
	end

	// Last cycle of a column, and whether that column finishes the transfer
	logic        col_end;
	logic        last_col;

	assign col_end = (state_r == MCC_COL) && (cnt_r <= 3'd1);
	assign last_col = (rem_r <= chunk_r);

	// Sequencer
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_r <= MCC_IDLE;
			req_r <= '0;
			p_r <= '0;
			chunk_r <= '0;
			rem_r <= '0;
			cnt_r <= '0;
		end else begin
			case (state_r)
				MCC_IDLE: begin
					if (REQ_VALID_I && REQ_READY_O) begin
						req_r <= REQ_I;
						state_r <= MCC_ROW;
					end
				end
				MCC_ROW: begin
					state_r <= MCC_COL;
					p_r <= nxt_p;
					chunk_r <= nxt_chunk;
					rem_r <= nxt_rem;
					cnt_r <= nxt_cnt;
				end
				MCC_COL: begin
					if (cnt_r > 3'd1) begin
						cnt_r <= cnt_r - 3'd1;
					end else if (rem_r <= chunk_r) begin
						state_r <= MCC_DONE;
					end else begin
						p_r <= nxt_p;
						chunk_r <= nxt_chunk;
						rem_r <= nxt_rem;
						cnt_r <= nxt_cnt;
					end
				end
				MCC_DONE: begin
					state_r <= MCC_IDLE;
				end
				default: begin
					state_r <= MCC_IDLE;
				end
			endcase
		end
	end

	// Row-time selections, held until the next row
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sel_r <= '0;
			tim_r <= '0;
		end else if (state_r == MCC_ROW) begin
			sel_r <= SEL_I;
			tim_r <= cur_tim;
		end
	end

	// Pin drive, registered one cycle ahead of the state it belongs to
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			MEM_STATUS_O <= `MCC_ST_IDLE_CODE;
			MEM_ADDR_O <= '0;
			MEM_ROW_O <= 1'b0;
			MEM_COL_O <= 1'b0;
			MEM_BYTE_EN_O <= '0;
			MEM_DATA_O <= '0;
			MEM_DATA_OE_N_O <= 1'b1;
		end else begin
			case (state_r)
				MCC_IDLE: begin
					if (REQ_VALID_I && REQ_READY_O) begin
						MEM_STATUS_O <= REQ_I.row_code;
						MEM_ADDR_O <= REQ_I.addr;
						MEM_ROW_O <= 1'b1;
					end
				end
				MCC_ROW, MCC_COL: begin
					if (state_r == MCC_ROW || (cnt_r <= 3'd1 && rem_r > chunk_r)) begin
						MEM_STATUS_O <= col_code(req_r.who, nxt_last);
						MEM_ADDR_O <= col_addr({req_r.addr[31:3], nxt_p[2:0]},
							cur_sel.addr_shift_sel);
						MEM_ROW_O <= 1'b0;
						MEM_COL_O <= 1'b1;
						MEM_BYTE_EN_O <= nxt_en;
						MEM_DATA_O <= req_r.write ? nxt_data : '0;
						MEM_DATA_OE_N_O <= ~req_r.write;
					end else if (cnt_r <= 3'd1) begin
						MEM_STATUS_O <= `MCC_ST_IDLE_CODE;
						MEM_COL_O <= 1'b0;
						MEM_BYTE_EN_O <= '0;
						MEM_DATA_OE_N_O <= 1'b1;
					end
				end
				default: begin
					MEM_STATUS_O <= `MCC_ST_IDLE_CODE;
					MEM_ROW_O <= 1'b0;
					MEM_COL_O <= 1'b0;
					MEM_BYTE_EN_O <= '0;
					MEM_DATA_OE_N_O <= 1'b1;
				end
			endcase
		end
	end

	// Read data and completion
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rdata_r <= '0;
			RDATA_O <= '0;
			DONE_O <= 1'b0;
		end else begin
			DONE_O <= 1'b0;
			if (state_r == MCC_ROW) begin
				rdata_r <= '0;
			end else if (col_end && !req_r.write) begin
				rdata_r <= cap_data;
			end
			if (col_end && last_col) begin
				DONE_O <= 1'b1;
				RDATA_O <= req_r.write ? rdata_r : cap_data;
			end
		end
	end

	assign REQ_READY_O = (state_r == MCC_IDLE) && ctrl_r[`MCC_CTRL_EN_BIT];
	assign TIMING_O = tim_r;

	// APB slave, zero wait states; read data is captured in the setup cycle
	logic apb_hit;

	assign apb_hit = (PADDR_I == `MCC_REG_CTRL) || (PADDR_I == `MCC_REG_STAT);
	assign PREADY_O = PSEL_I && PENABLE_I;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !apb_hit;
	assign PRDATA_O = prdata_r;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ctrl_r <= `MCC_CTRL_RESET;
		end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `MCC_REG_CTRL) begin
			ctrl_r <= PWDATA_I[1:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			prdata_r <= '0;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			case (PADDR_I)
				`MCC_REG_CTRL: prdata_r <= {30'd0, ctrl_r};
				// State in 21:18, timing in 17:9, selections in 8:0
				`MCC_REG_STAT: prdata_r <= {10'd0, state_r, tim_r, sel_r};
				default:       prdata_r <= '0;
			endcase
		end
	end

endmodule // mcc_column

// *** mcc_column_monitor.sv ***
// Assertion checker watching the column-time block's ports
`timescale 1ns/1ps
module mcc_column_monitor (
	input wire logic                 SYS_CLK_I,
	input wire logic                 RESETN_I,
	input wire logic                 REQ_VALID_I,
	input wire logic                 REQ_READY_O,
	input wire mcc_pkg::mcc_req_t    REQ_I,
	input wire logic                 DONE_O,
	input wire mcc_pkg::mcc_sel_t    SEL_I,
	input wire logic [5:0]           MEM_STATUS_O,
	input wire logic [31:0]          MEM_ADDR_O,
	input wire logic                 MEM_ROW_O,
	input wire logic                 MEM_COL_O,
	input wire logic [7:0]           MEM_BYTE_EN_O,
	input wire mcc_pkg::mcc_timing_t TIMING_O
);
	import mcc_pkg::*;
	mcc_requester_t who_r;
	logic [31:0]    addr_r;
	logic [2:0]     as_r;
	logic [1:0]     bw_r;
	logic [3:0]     ts_r;
	logic [15:0]    lanes;
	logic [4:0]     sh;
	logic [5:0]     code;
	logic           take;
	assign take = REQ_VALID_I && REQ_READY_O;
	assign sh   = (as_r == 3'h0) ? 5'h0 : 5'(as_r) + 5'h7;
	// Selections are kept from the row cycle so columns are judged by them
	always_ff @(posedge SYS_CLK_I) begin
		if (take) begin
			who_r  <= REQ_I.who;
			addr_r <= REQ_I.addr;
		end
		if (MEM_ROW_O) begin
			as_r <= SEL_I.addr_shift_sel;
			bw_r <= SEL_I.bus_width_sel;
			ts_r <= {SEL_I.user_timing_bit, SEL_I.cycle_timing_sel};
		end
	end
	// Endianness is not visible here, so either end lane group is accepted
	always_comb begin
		case (bw_r)
			2'h0: lanes = 16'h8001;
			2'h1: lanes = 16'hC003;
			2'h2: lanes = 16'hF00F;
			default: lanes = 16'hFFFF;
		endcase
		case (who_r.unit)
			MCC_SRC_PP: code = {2'h0, who_r.pp_num, who_r.kind};
			MCC_SRC_MP_PT: code = {4'h4, who_r.kind};
			MCC_SRC_MP_IC: code = {5'h0B, who_r.high_pri};
			MCC_SRC_MP_DEA: code = {5'h0C, who_r.high_pri};
			MCC_SRC_MP_DC: code = {5'h0D, who_r.high_pri};
			MCC_SRC_FRAME0: code = 6'h1C;
			MCC_SRC_FRAME1: code = 6'h1D;
			MCC_SRC_REFRESH: code = 6'h1E;
			MCC_SRC_DRAIN: code = 6'h3F;
			default: code = 6'h14;
		endcase
	end
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	a_idle_status: assert property (!MEM_ROW_O && !MEM_COL_O |-> MEM_STATUS_O == 6'h1F)
		else $error("idle status wrong");
	a_row_phase: assert property (take |=> MEM_ROW_O && MEM_ADDR_O == $past(REQ_I.addr)
		&& MEM_STATUS_O == $past(REQ_I.row_code)) else $error("row phase wrong");
	a_col_code: assert property (MEM_COL_O |-> MEM_STATUS_O == code
		|| (code == 6'h14 && MEM_STATUS_O == 6'h15)) else $error("column code wrong");
	a_no_reserved: assert property (MEM_COL_O && MEM_STATUS_O[5] |-> &MEM_STATUS_O)
		else $error("reserved status driven");
	a_xfer_running: assert property (MEM_COL_O && MEM_STATUS_O == 6'h14 |=> MEM_COL_O)
		else $error("running code on final column");
	a_xfer_complete: assert property (MEM_COL_O && MEM_STATUS_O == 6'h15
		|=> !MEM_COL_O || $stable(MEM_ADDR_O)) else $error("complete code before final column");
	a_lane_group: assert property (MEM_COL_O |-> (MEM_BYTE_EN_O & ~lanes[7:0]) == 8'h00
		|| (MEM_BYTE_EN_O & ~lanes[15:8]) == 8'h00) else $error("strobe outside lanes");
	a_col_addr: assert property (MEM_COL_O |-> ((MEM_ADDR_O ^ (addr_r << sh))
		& (32'hFFFF_FFF8 << sh)) == 32'h0) else $error("column address wrong");
	a_dram_decode: assert property ($fell(MEM_ROW_O) && ts_r[2] |-> !TIMING_O.sdram
		&& TIMING_O.cyc_per_col == 2'h1 + ts_r[1] + (ts_r[1] & ts_r[0]))
		else $error("dram timing wrong");
	a_sdram_decode: assert property ($fell(MEM_ROW_O) && !ts_r[2] |-> TIMING_O.sdram
		&& TIMING_O.burst_two == ts_r[1] && TIMING_O.read_lat == (ts_r[3] ? 3'h2 + ts_r[0] : 3'h4))
		else $error("sdram timing wrong");
	a_timing_hold: assert property (!$past(MEM_ROW_O) |-> $stable(TIMING_O))
		else $error("timing changed");
	a_done_bound: assert property (take |-> ##[3:40] DONE_O)
		else $error("transfer not done");
endmodule // mcc_column_monitor

bind mcc_column mcc_column_monitor i_mcc_column_monitor (
	.SYS_CLK_I, .RESETN_I, .REQ_VALID_I, .REQ_READY_O, .REQ_I, .DONE_O, .SEL_I,
	.MEM_STATUS_O, .MEM_ADDR_O, .MEM_ROW_O, .MEM_COL_O, .MEM_BYTE_EN_O, .TIMING_O
);

// *** mcc_consts.svh ***
// Constants for the memory interface column-time block
`ifndef MCC_CONSTS_SVH
`define MCC_CONSTS_SVH

`define MCC_REG_CTRL       12'h000
`define MCC_REG_STAT       12'h004
`define MCC_CTRL_BE_BIT    0
`define MCC_CTRL_EN_BIT    1
`define MCC_CTRL_RESET     2'h2
`define MCC_ST_IDLE_CODE   6'h1F
`define MCC_ST_XPT_RUN     6'h14
`define MCC_ST_XPT_END     6'h15
`define MCC_ST_FRAME0      6'h1C
`define MCC_ST_FRAME1      6'h1D
`define MCC_ST_REFRESH     6'h1E
`define MCC_ST_DRAIN       6'h3F
`define MCC_ST_MP_PT       4'h4
`define MCC_ST_MP_ICACHE   5'h0B
`define MCC_ST_MP_DEA      5'h0C
`define MCC_ST_MP_DCACHE   5'h0D
`define MCC_SHIFT_BASE     6'd7
`define MCC_LAT_SDRAM_LO   3'd2
`define MCC_LAT_SDRAM_HI   3'd3
`define MCC_LAT_SDRAM_USR  3'd4

`endif

// *** mcc_mem_model.sv ***
// Behavioural byte memory standing on the far side of the data bus
`timescale 1ns/1ps
module mcc_mem_model (
	input  wire logic        clk_i,
	input  wire logic [1:0]  bw_i,
	input  wire logic        be_i,
	input  wire logic        col_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  ben_i,
	input  wire logic [63:0] data_i,
	input  wire logic        oe_n_i,
	output logic      [63:0] data_o
);
	logic [7:0]  mem [8];
	logic [63:0] last = 64'h0;
	// Byte offset carried by lane l for the current width and byte order
	function automatic int slot(int l);
		return ((addr_i[2:0] & ~((3'h1 << bw_i) - 3'h1)) + (be_i ? 7 - l : l)) % 8;
	endfunction
	initial for (int k = 0; k < 8; k++) mem[k] = 8'h5A ^ 8'(k);
	always @(posedge clk_i) begin
		last <= data_o;
		for (int l = 0; l < 8; l++)
			if (col_i && !oe_n_i && ben_i[l]) mem[slot(l)] <= data_i[8*l +: 8];
	end
	// A released bus keeps changing so a stale value can never pass
	always_comb
		for (int l = 0; l < 8; l++)
			data_o[8*l +: 8] = (col_i && oe_n_i) ? mem[slot(l)] : ~last[8*l +: 8];
endmodule // mcc_mem_model

// *** mcc_pkg.sv ***
// Types shared by the memory interface column-time block
package mcc_pkg;

	typedef enum logic [3:0] {
		MCC_SRC_PP      = 4'h0,
		MCC_SRC_MP_PT   = 4'h1,
		MCC_SRC_MP_IC   = 4'h2,
		MCC_SRC_MP_DEA  = 4'h3,
		MCC_SRC_MP_DC   = 4'h4,
		MCC_SRC_XPT     = 4'h5,
		MCC_SRC_FRAME0  = 4'h6,
		MCC_SRC_FRAME1  = 4'h7,
		MCC_SRC_REFRESH = 4'h8,
		MCC_SRC_DRAIN   = 4'h9
	} mcc_src_t;

	typedef struct packed {
		mcc_src_t    unit;
		logic [1:0]  pp_num;
		logic [1:0]  kind;
		logic        high_pri;
	} mcc_requester_t;

	typedef struct packed {
		logic [31:0]    addr;
		logic [63:0]    wdata;
		logic [3:0]     nbytes;
		logic           write;
		logic [5:0]     row_code;
		mcc_requester_t who;
	} mcc_req_t;

	typedef struct packed {
		logic [2:0] addr_shift_sel;
		logic [1:0] bus_width_sel;
		logic [2:0] cycle_timing_sel;
		logic       user_timing_bit;
	} mcc_sel_t;

	typedef struct packed {
		logic       sdram;
		logic       burst_two;
		logic [2:0] read_lat;
		logic [1:0] cyc_per_col;
		logic       pipelined;
		logic       reserved;
	} mcc_timing_t;

	typedef enum logic [3:0] {
		MCC_IDLE = 4'b0001,
		MCC_ROW  = 4'b0010,
		MCC_COL  = 4'b0100,
		MCC_DONE = 4'b1000
	} mcc_state_t;

endpackage

// *** mem_if_column_config_bench.sv ***
// Self-checking bench for the column-time memory interface block
`timescale 1ns/1ps
module mem_if_column_config_bench;
	import mcc_pkg::*;
	typedef struct packed {
		logic [8:0] sel;
		logic [2:0] off;
		logic [3:0] n;
		logic       wr;
		logic [8:0] who;
	} mcc_row_t;
	logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        valid = 1'b0, be = 1'b0, pready, pslverr, ready, done, row, col, oe_n;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, maddr;
	logic [63:0] rdata, mdout, mdin;
	logic [7:0]  ben;
	logic [5:0]  status;
	mcc_req_t    req = '0;
	mcc_sel_t    sel = '0;
	mcc_timing_t timing;
	mcc_row_t    rows [11];
	logic [7:0]  sh [8];
	int          miscompares = 0;
	int          num_checks = 0;

	always #25 clk = ~clk;

	mcc_column i_mcc_column (.SYS_CLK_I(clk), .RESETN_I(resetn), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .REQ_VALID_I(valid),
		.REQ_READY_O(ready), .REQ_I(req), .DONE_O(done), .RDATA_O(rdata), .SEL_I(sel),
		.MEM_STATUS_O(status), .MEM_ADDR_O(maddr), .MEM_ROW_O(row), .MEM_COL_O(col),
		.MEM_BYTE_EN_O(ben), .MEM_DATA_O(mdout), .MEM_DATA_OE_N_O(oe_n), .MEM_DATA_I(mdin),
		.TIMING_O(timing));
	mcc_mem_model i_mcc_mem_model (.clk_i(clk), .bw_i(sel.bus_width_sel), .be_i(be),
		.col_i(col), .addr_i(maddr), .ben_i(ben), .data_i(mdout), .oe_n_i(oe_n), .data_o(mdin));

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(string what, logic [63:0] e, logic [63:0] g);
		num_checks++;
		if (e !== g) begin
			$display("Error %s expected %h seen %h", what, e, g);
			miscompares++;
		end
	endtask

	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk("apb ready", 1, 0);
			stop_test();
		end
	endtask

	// Column length from the timing select: DRAM fixed, SDRAM read waits latency
	function automatic int clen(logic [8:0] s, logic wr);
		if (s[3]) return (s[2:1] == 2'h3) ? 3 : s[2] ? 2 : 1;
		if (wr) return 1;
		return !s[0] ? 4 : s[1] ? 3 : 2;
	endfunction

	task automatic run(int i);
		logic [63:0] wd, e, m;
		int o, c, t, w;
		mcc_row_t r;
		r = rows[i];
		o = r.off;
		w = 1 << r.sel[5:4];
		wd = 64'h0123_4567_89AB_CDEF ^ {8{8'(i * 37)}};
		@(posedge clk);
		sel <= r.sel;
		req <= '{addr: {20'h8_6421, 4'(i), 5'h0, r.off}, wdata: wd, nbytes: r.n, write: r.wr,
			row_code: 6'(i), who: r.who};
		valid <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (ready !== 1'b1 && t < 8);
		valid <= 1'b0;
		if (ready !== 1'b1) begin
			chk("request ready", 1, 0);
			stop_test();
		end
		c = ((o + r.n - 1) / w) - (o / w) + 1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (done !== 1'b1 && t < 60);
		chk("cycles", 2 + c * clen(r.sel, r.wr), t);
		if (done !== 1'b1) stop_test();
		e = '0;
		m = '0;
		for (int k = o; k < o + r.n; k++) begin
			m[8*k +: 8] = 8'hFF;
			if (r.wr) sh[k] = wd[8*k +: 8];
			e[8*k +: 8] = sh[k];
			if (r.wr) chk("stored byte", sh[k], i_mcc_mem_model.mem[k]);
		end
		if (!r.wr) chk("read data", e, rdata & m);
	endtask

	initial begin
		logic [31:0] rd;
		logic        err;
		for (int k = 0; k < 8; k++) sh[k] = 8'h5A ^ 8'(k);
		rows = '{'{9'h00B, 3'h0, 4'h2, 1'b1, 9'h00C}, '{9'h00B, 3'h0, 4'h2, 1'b0, 9'h01E},
			'{9'h0DD, 3'h1, 4'h4, 1'b1, 9'h041}, '{9'h1E1, 3'h0, 4'h8, 1'b0, 9'h060},
			'{9'h07E, 3'h0, 4'h8, 1'b1, 9'h081}, '{9'h0B2, 3'h3, 4'h5, 1'b0, 9'h026},
			'{9'h109, 3'h7, 4'h1, 1'b0, 9'h120}, '{9'h157, 3'h6, 4'h2, 1'b1, 9'h0C0},
			'{9'h1A7, 3'h4, 4'h4, 1'b0, 9'h0E0}, '{9'h025, 3'h0, 4'h3, 1'b1, 9'h100},
			'{9'h003, 3'h0, 4'h3, 1'b0, 9'h0A0}};
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		chk("reset status", 6'h1F, status);
		chk("reset ready", 1, ready);
		chk("reset bus drive", 1, oe_n);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk("control reset", 32'h2, rd);
		chk("mapped error", 0, err);
		apb(1'b0, 12'h00C, 32'h0, rd, err);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		for (int i = 0; i < 11; i++) run(i);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		chk("status word", 32'h0006_6803, rd);
		apb(1'b1, 12'h000, 32'h3, rd, err);
		be <= 1'b1;
		run(2);
		run(3);
		run(0);
		run(1);
		apb(1'b1, 12'h000, 32'h1, rd, err);
		@(posedge clk);
		chk("ready disabled", 0, ready);
		// Reset in the middle of a read column, then a clean transfer afterwards
		apb(1'b1, 12'h000, 32'h3, rd, err);
		sel <= rows[10].sel;
		valid <= 1'b1;
		repeat (4) @(posedge clk);
		valid <= 1'b0;
		resetn <= 1'b0;
		be <= 1'b0;
		@(posedge clk);
		chk("mid reset status", 6'h1F, status);
		chk("mid reset column", 0, col);
		chk("mid reset done", 0, done);
		chk("mid reset bus drive", 1, oe_n);
		chk("mid reset read data", 0, rdata);
		resetn <= 1'b1;
		@(posedge clk);
		chk("mid reset ready", 1, ready);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk("control after reset", 32'h2, rd);
		run(1);
		stop_test();
	end
endmodule // mem_if_column_config_bench
